// [rtl/pio_sdr_ddr_register_cell.sv]
// programmable i/o register cell between fabric core and pad buffer
// assumes pad and core inputs are synchronous to i_ref_clk
`timescale 1ns/10ps

module pio_sdr_ddr_register_cell (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_local_rst,
  input wire logic i_clk_en,
  input wire pio_cell_pkg::data_rate_t i_in_rate,
  input wire pio_cell_pkg::data_rate_t i_out_rate,
  input wire logic i_pad_in,
  input wire pio_cell_pkg::core_tx_t i_core_tx,
  output logic o_bypass_comb_input,
  output logic o_bypass_clk_output,
  output logic o_rise_capture_out,
  output logic o_fall_or_sdr_capture_out,
  output logic o_pad_data_out,
  output logic o_pad_tristate_out
);

  `include "pio_cell_defs.svh"

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  pio_cell_pkg::data_rate_t in_rate_q;
  pio_cell_pkg::data_rate_t out_rate_q;
  logic rise_q;
  logic fall_neg_q;
  logic fall_out_q;
  logic out_hi_q;
  logic out_second_q;
  logic out_lo_q;
  logic ts_q;
  logic upd;

  // update only when enabled and not held in local reset
  assign upd = i_clk_en && !i_local_rst;

  // ----------------------------------------------------------------------
  // mode selection
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      in_rate_q <= pio_cell_pkg::rate_sdr;
      out_rate_q <= pio_cell_pkg::rate_sdr;
    end else begin
      in_rate_q <= i_in_rate;
      out_rate_q <= i_out_rate;
    end
  end

  // ----------------------------------------------------------------------
  // input section: bypass
  // ----------------------------------------------------------------------
  // pad copies are combinational by nature of a bypass
  assign o_bypass_comb_input = i_pad_in;
  assign o_bypass_clk_output = i_pad_in;

  // ----------------------------------------------------------------------
  // input section: rising-edge capture
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rise_q <= `PIO_DATA_INIT;
    end else if (i_local_rst) begin
      rise_q <= `PIO_DATA_INIT;
    end else if (i_clk_en) begin
      rise_q <= i_pad_in;
    end
  end

  // ----------------------------------------------------------------------
  // input section: falling-edge capture
  // ----------------------------------------------------------------------
  always_ff @(negedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fall_neg_q <= `PIO_DATA_INIT;
    end else if (i_local_rst) begin
      fall_neg_q <= `PIO_DATA_INIT;
    end else if (i_clk_en) begin
      fall_neg_q <= i_pad_in;
    end
  end

  // retimes the falling sample, or takes the sdr sample directly
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fall_out_q <= `PIO_DATA_INIT;
    end else if (i_local_rst) begin
      fall_out_q <= `PIO_DATA_INIT;
    end else if (i_clk_en) begin
      case (in_rate_q)
        pio_cell_pkg::rate_sdr: fall_out_q <= i_pad_in;
        pio_cell_pkg::rate_ddr: fall_out_q <= fall_neg_q;
        default: fall_out_q <= i_pad_in;
      endcase
    end
  end

  assign o_rise_capture_out = rise_q;
  assign o_fall_or_sdr_capture_out = fall_out_q;

  // ----------------------------------------------------------------------
  // output section
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      out_hi_q <= `PIO_DATA_INIT;
      out_second_q <= `PIO_DATA_INIT;
    end else if (i_local_rst) begin
      out_hi_q <= `PIO_DATA_INIT;
      out_second_q <= `PIO_DATA_INIT;
    end else if (i_clk_en) begin
      out_hi_q <= i_core_tx.core_out_first;
      out_second_q <= i_core_tx.core_out_second;
    end
  end

  // second word moves to the low-phase register at the falling edge
  always_ff @(negedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      out_lo_q <= `PIO_DATA_INIT;
    end else if (i_local_rst) begin
      out_lo_q <= `PIO_DATA_INIT;
    end else if (i_clk_en) begin
      out_lo_q <= out_second_q;
    end
  end

  // phase select between two flops; sdr never looks at the second word
  always_comb begin
    case (out_rate_q)
      pio_cell_pkg::rate_sdr: o_pad_data_out = out_hi_q;
      pio_cell_pkg::rate_ddr: o_pad_data_out = i_ref_clk ? out_hi_q : out_lo_q;
      default: o_pad_data_out = out_hi_q;
    endcase
  end

  // ----------------------------------------------------------------------
  // tri-state section
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ts_q <= `PIO_TS_INIT;
    end else if (i_local_rst) begin
      ts_q <= `PIO_TS_INIT;
    end else if (i_clk_en) begin
      ts_q <= i_core_tx.core_tristate_ctl;
    end
  end

  assign o_pad_tristate_out = ts_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
    (!i_clk_en && !i_local_rst) |=>
      ($stable(rise_q) && $stable(fall_out_q) && $stable(out_hi_q) && $stable(ts_q));
  endproperty
  a_hold: assert property (p_hold) else $error("registers changed while disabled");

  property p_local_rst;
    @(posedge i_ref_clk) disable iff (i_rst)
    i_local_rst |=> (o_rise_capture_out == `PIO_DATA_INIT) &&
      (o_pad_tristate_out == `PIO_TS_INIT) && (out_hi_q == `PIO_DATA_INIT);
  endproperty
  a_local_rst: assert property (p_local_rst) else $error("local reset not applied");

  property p_rise;
    @(posedge i_ref_clk) disable iff (i_rst)
    upd |=> o_rise_capture_out == $past(i_pad_in);
  endproperty
  a_rise: assert property (p_rise) else $error("rising capture wrong");

  property p_sdr_in;
    @(posedge i_ref_clk) disable iff (i_rst)
    (upd && in_rate_q == pio_cell_pkg::rate_sdr) |=>
      o_fall_or_sdr_capture_out == $past(i_pad_in);
  endproperty
  a_sdr_in: assert property (p_sdr_in) else $error("sdr capture wrong");

  property p_ddr_in;
    @(posedge i_ref_clk) disable iff (i_rst)
    (upd && in_rate_q == pio_cell_pkg::rate_ddr) |=>
      o_fall_or_sdr_capture_out == $past(fall_neg_q);
  endproperty
  a_ddr_in: assert property (p_ddr_in) else $error("ddr falling capture wrong");

  property p_out_first;
    @(posedge i_ref_clk) disable iff (i_rst)
    upd |=> out_hi_q == $past(i_core_tx.core_out_first);
  endproperty
  a_out_first: assert property (p_out_first) else $error("first word not registered");

  property p_sdr_out;
    @(posedge i_ref_clk) disable iff (i_rst)
    (out_rate_q == pio_cell_pkg::rate_sdr) |-> o_pad_data_out == out_hi_q;
  endproperty
  a_sdr_out: assert property (p_sdr_out) else $error("sdr pad data wrong");

  property p_ddr_high;
    @(negedge i_ref_clk) disable iff (i_rst)
    (out_rate_q == pio_cell_pkg::rate_ddr) |-> o_pad_data_out == out_hi_q;
  endproperty
  a_ddr_high: assert property (p_ddr_high) else $error("high phase not first word");

  property p_ddr_low;
    @(posedge i_ref_clk) disable iff (i_rst)
    (out_rate_q == pio_cell_pkg::rate_ddr) |-> o_pad_data_out == out_lo_q;
  endproperty
  a_ddr_low: assert property (p_ddr_low) else $error("low phase not second word");

  property p_ts;
    @(posedge i_ref_clk) disable iff (i_rst)
    upd |=> o_pad_tristate_out == $past(i_core_tx.core_tristate_ctl);
  endproperty
  a_ts: assert property (p_ts) else $error("tristate control not passed");

endmodule

// [rtl/pio_cell_defs.svh]
// constants of the programmable i/o register cell
// assumes inclusion by bare name from the cell
`ifndef PIO_CELL_DEFS_SVH
`define PIO_CELL_DEFS_SVH

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PIO_DATA_INIT 1'h0
`define PIO_TS_INIT 1'h1

`endif

// [rtl/pio_cell_pkg.sv]
// types shared by the programmable i/o register cell and its users
// assumes nothing beyond a systemverilog compiler
package pio_cell_pkg;

  // ----------------------------------------------------------------------
  // data rate of the input or output section
  // ----------------------------------------------------------------------
  typedef enum logic {
    rate_sdr,
    rate_ddr
  } data_rate_t;

  // ----------------------------------------------------------------------
  // words the core drives toward the pad
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic core_out_first;
    logic core_out_second;
    logic core_tristate_ctl;
  } core_tx_t;

endpackage

// [verification/pad_line_model.sv]
// far-side pad line: the level the i/o buffer hands to the cell
// assumes one clock; the line moves on both edges to exercise ddr capture
`timescale 1ns/10ps

module pad_line_model (
  input wire logic i_ref_clk,
  output logic o_pad
);
  logic [31:0] seed;

  initial begin
    seed = 32'h1D2C;
    o_pad = 1'h0;
  end

  // random level after every edge so rising and falling samples can differ
  always @(posedge i_ref_clk or negedge i_ref_clk) begin
    o_pad <= 1'($random(seed));
  end
endmodule

// [verification/tb.sv]
// self-checking bench of the pio register cell
// assumes pad_line_model drives the pad; bench drives the core side
`timescale 1ns/10ps

module tb;
  logic clk, rst, lrst, en, pad;
  logic [31:0] seed, r;
  pio_cell_pkg::core_tx_t tx;
  pio_cell_pkg::data_rate_t in_rate, out_rate, in_m, out_m;
  logic rise, fall, fneg, ts, hi, sec, lo;
  logic o_comb, o_ck, o_rise, o_fall, o_pad, o_ts;
  int fails, checked, cycles, ph, k;

  pad_line_model partner (.i_ref_clk(clk), .o_pad(pad));

  pio_sdr_ddr_register_cell uut (
    .i_ref_clk(clk), .i_rst(rst), .i_local_rst(lrst), .i_clk_en(en),
    .i_in_rate(in_rate), .i_out_rate(out_rate), .i_pad_in(pad),
    .i_core_tx(tx), .o_bypass_comb_input(o_comb),
    .o_bypass_clk_output(o_ck), .o_rise_capture_out(o_rise),
    .o_fall_or_sdr_capture_out(o_fall), .o_pad_data_out(o_pad),
    .o_pad_tristate_out(o_ts)
  );

  always #2 clk = ~clk;

  // ----------------------------------------------------------------------
  // checking and expectations
  // ----------------------------------------------------------------------
  task check(input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    if (fails == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  function logic exp_fall(input pio_cell_pkg::data_rate_t m, input logic p, input logic f);
    return (m == pio_cell_pkg::rate_ddr) ? f : p;
  endfunction

  function logic exp_pad(input pio_cell_pkg::data_rate_t m, input logic c, input logic h,
                         input logic l);
    return (m == pio_cell_pkg::rate_ddr && !c) ? l : h;
  endfunction

  task model_init;
    in_m = pio_cell_pkg::rate_sdr;
    out_m = pio_cell_pkg::rate_sdr;
    {rise, fall, fneg, hi, sec, lo} = 6'h00;
    ts = 1'h1;
  endtask

  // inputs are read before the bench's own updates of this edge land
  always @(posedge clk) begin
    if (!rst && lrst) begin
      {rise, fall, hi, sec} = 4'h0;
      ts = 1'h1;
    end else if (!rst && en) begin
      fall = exp_fall(in_m, pad, fneg);
      rise = pad;
      hi = tx.core_out_first;
      sec = tx.core_out_second;
      ts = tx.core_tristate_ctl;
    end
    if (!rst) begin
      in_m = in_rate;
      out_m = out_rate;
    end
    #1;
    if (rst) model_init;
    check(o_rise, rise);
    check(o_fall, fall);
    check(o_ts, ts);
    check(o_pad, exp_pad(out_m, 1'h1, hi, lo));
    check(o_comb, pad);
  end

  always @(negedge clk) begin
    if (!rst && lrst) {fneg, lo} = 2'h0;
    else if (!rst && en) begin
      fneg = pad;
      lo = sec;
    end
    #1;
    if (rst) model_init;
    check(o_pad, exp_pad(out_m, 1'h0, hi, lo));
    check(o_ck, pad);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      report_and_stop;
    end
  end

  // ----------------------------------------------------------------------
  // stimulus: every rate pair, random enables and local resets
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'h5848;
    clk = 1'h0;
    rst = 1'h1;
    lrst = 1'h0;
    en = 1'h1;
    tx = 3'h0;
    in_rate = pio_cell_pkg::rate_sdr;
    out_rate = pio_cell_pkg::rate_sdr;
    model_init;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    for (ph = 0; ph < 8; ph++) begin
      in_rate <= pio_cell_pkg::data_rate_t'(ph[0]);
      out_rate <= pio_cell_pkg::data_rate_t'(ph[1]);
      en <= 1'h1;
      lrst <= 1'h0;
      repeat (2) @(posedge clk);
      for (k = 0; k < 40; k++) begin
        r = $random(seed);
        tx <= r[2:0];
        en <= (r[5:4] != 2'h0) || ph[2];
        lrst <= (r[9:7] == 3'h0);
        @(posedge clk);
      end
      if (ph == 3) begin
        rst <= 1'h1;
        @(posedge clk);
        rst <= 1'h0;
      end
    end
    report_and_stop;
  end
endmodule
